// ---- src/sram_device.sv ----
`timescale 1ns/1ns
module sram_device (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory command pins
   input wire logic [sram_pkg::MEM_AW-1:0] addr,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic write_enable_n,
   input wire logic advance_or_load,
   input wire logic [sram_pkg::LANES-1:0] byte_write_select_n,
   input wire logic clock_qualify_n,
   input wire logic output_enable_n,
   input wire logic burst_order_mode,
   input wire logic sleep_request,
   // Data and parity lanes
   input wire logic [sram_pkg::DATA_W-1:0] dq_in,
   output logic [sram_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [sram_pkg::LANES-1:0] parity_lane_in,
   output logic [sram_pkg::LANES-1:0] parity_lane_out,
   output logic parity_lane_oe,
   // Test port
   input wire logic test_clock,
   input wire logic test_mode_select,
   input wire logic test_data_in,
   output logic test_data_out,
   output logic test_data_out_oe
);
   import sram_pkg::*;

   // Burst address: low two bits walk in the chosen order
   function automatic logic [MEM_AW-1:0] burst_addr(
      input logic [MEM_AW-1:0] base, input logic [1:0] cnt,
      input logic interleave);
      logic [1:0] low;
      low = interleave ? (base[1:0] ^ cnt) : (base[1:0] + cnt);
      return {base[MEM_AW-1:2], low};
   endfunction

   // Array, parity bits in the top lanes
   logic [WORD_W-1:0] mem_q [MEM_DEPTH];

   // Address stage and data stage of the pipeline
   logic a_valid_q, a_write_q, b_valid_q, b_write_q;
   logic [MEM_AW-1:0] a_base_q, b_addr_q;
   logic [1:0] a_cnt_q;
   logic [LANES-1:0] a_bw_q, b_bw_q;
   logic [WORD_W-1:0] out_q;
   logic read_drive_q, oe_q;
   logic sleep_meta_q, asleep_q;

   // Registers
   logic log_en_q, overflow_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;

   // Test port
   tap_state_t tap_q, tap_d;
   logic tck_q, tdo_q, tdo_oe_q, bypass_q;
   logic [IR_W-1:0] ir_sh_q, ir_q;

   log_fifo_if #(.WIDTH(LOG_W)) log_bus ();

   log_fifo #(.WIDTH(LOG_W), .DEPTH(LOG_DEPTH)) u_log (
      .clk(pclk),
      .rst_n(presetn),
      .port(log_bus.store)
   );

   // Qualified edge; a stretched cycle holds the pipeline, but lane drive still follows OE and sleep
   wire step = !clock_qualify_n;
   wire interleave = burst_order_mode;
   wire selected = !chip_select_first_n && chip_select_second &&
                   !chip_select_third_n;
   wire load = !advance_or_load;
   wire [1:0] a_cnt_d = load ? 2'h0 : a_cnt_q + 2'h1;
   wire a_valid_d = asleep_q ? 1'b0 : (load ? selected : a_valid_q);
   wire [MEM_AW-1:0] a_addr = burst_addr(a_base_q, a_cnt_q, interleave);
   wire a_read = a_valid_q && !a_write_q;
   wire b_commit = step && b_valid_q && b_write_q && !asleep_q;

   // Drive only for a read in its data phase, never while asleep
   wire read_drive_d = asleep_q ? 1'b0 : (step ? a_read : read_drive_q);

   // Sleep input is asynchronous, so it is brought in through two stages
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sleep_meta_q <= 1'b0;
         asleep_q <= 1'b0;
      end
      else
      begin
         sleep_meta_q <= sleep_request;
         asleep_q <= sleep_meta_q;
      end
   end

   // Address stage: load, or advance the held burst
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_valid_q <= 1'b0;
         a_write_q <= 1'b0;
         a_base_q <= '0;
         a_cnt_q <= 2'h0;
         a_bw_q <= '0;
      end
      else if (step)
      begin
         a_valid_q <= a_valid_d;
         a_cnt_q <= a_cnt_d;
         a_bw_q <= ~byte_write_select_n;
         if (load)
         begin
            a_write_q <= !write_enable_n;
            a_base_q <= addr;
         end
      end
   end

   // Data stage follows the address stage by one qualified edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         b_valid_q <= 1'b0;
         b_write_q <= 1'b0;
         b_addr_q <= '0;
         b_bw_q <= '0;
         read_drive_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else
      begin
         if (step)
         begin
            b_valid_q <= a_valid_q && !asleep_q;
            b_write_q <= a_write_q;
            b_addr_q <= a_addr;
            b_bw_q <= a_bw_q & {LANES{a_write_q}};
         end
         read_drive_q <= read_drive_d;
         oe_q <= read_drive_d && !output_enable_n;
      end
   end

   // Output register; held through a stretched cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_q <= '0;
      else if (step && a_read)
         out_q <= mem_q[a_addr];
   end

   // Lane data taken at the edge ending the write data phase
   always_ff @(posedge pclk)
   begin
      for (int k = 0; k < LANES; k++)
      begin
         if (b_commit && b_bw_q[k])
         begin
            mem_q[b_addr_q][k*8 +: 8] <= dq_in[k*8 +: 8];
            mem_q[b_addr_q][DATA_W+k] <= parity_lane_in[k];
         end
      end
   end

   assign dq_out = out_q[DATA_W-1:0];
   assign parity_lane_out = out_q[WORD_W-1:DATA_W];
   assign dq_oe = oe_q;
   assign parity_lane_oe = oe_q;

   // Write log: full buffer drops entries and flags overflow
   assign log_bus.push_valid = b_commit && log_en_q;
   assign log_bus.push_data = dq_in;

   // APB decode; one wait state gives time to form read data
   wire apb_setup = psel && penable && !pready_q;
   wire apb_done = psel && penable && pready_q;
   wire hit_ctrl = (paddr == CTRL_OFFSET);
   wire hit_status = (paddr == STATUS_OFFSET);
   wire hit_log = (paddr == LOG_OFFSET);
   wire hit_any = hit_ctrl || hit_status || hit_log;
   wire log_pop = apb_done && !pwrite && hit_log && log_bus.pop_valid;
   wire overflow_set = log_bus.push_valid && !log_bus.push_ready;
   wire overflow_clr = apb_done && pwrite && hit_status &&
                       pwdata[ST_OVERFLOW_BIT];
   assign log_bus.pop_ready = log_pop;

   // Status word reflects live pipeline state
   wire [31:0] status_word = 32'h0000_0000 |
      (32'(asleep_q) << ST_ASLEEP_BIT) |
      (32'(interleave) << ST_INTERLEAVE_BIT) |
      (32'(b_valid_q) << ST_ACTIVE_BIT) |
      (32'(overflow_q) << ST_OVERFLOW_BIT) |
      (32'(log_bus.pop_valid) << ST_LOG_AVAIL_BIT);
   wire [31:0] read_mux = hit_ctrl ? (32'(log_en_q) << CTRL_LOG_EN_BIT) :
                          hit_status ? status_word :
                          (hit_log && log_bus.pop_valid) ?
                          log_bus.pop_data : 32'h0000_0000;

   // Bus answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup && !hit_any;
         prdata_q <= (apb_setup && !pwrite) ? read_mux : 32'h0000_0000;
      end
   end

   // Software state; overflow set beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         log_en_q <= CTRL_LOG_EN_RESET;
         overflow_q <= 1'b0;
      end
      else
      begin
         if (apb_done && pwrite && hit_ctrl)
            log_en_q <= pwdata[CTRL_LOG_EN_BIT];
         if (overflow_set)
            overflow_q <= 1'b1;
         else if (overflow_clr)
            overflow_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // Test clock edges seen on pclk; test clock must be well below pclk
   wire tck_rise = test_clock && !tck_q;
   wire tck_fall = !test_clock && tck_q;
   wire shifting = (tap_q == TAP_SHIFT_IR) || (tap_q == TAP_SHIFT_DR);

   // Standard TAP transitions
   always_comb
   begin
      tap_d = tap_q;
      unique case (tap_q)
         TAP_RESET: tap_d = test_mode_select ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tap_d = test_mode_select ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_d = test_mode_select ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_d = test_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tap_d = test_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: tap_d = test_mode_select ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tap_d = test_mode_select ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: tap_d = test_mode_select ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: tap_d = test_mode_select ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_d = test_mode_select ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: tap_d = test_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tap_d = test_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: tap_d = test_mode_select ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tap_d = test_mode_select ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: tap_d = test_mode_select ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: tap_d = test_mode_select ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // TAP state, instruction and bypass move on rising test clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tck_q <= 1'b0;
         tap_q <= TAP_RESET;
         ir_sh_q <= '0;
         ir_q <= IR_RESET;
         bypass_q <= 1'b0;
      end
      else
      begin
         tck_q <= test_clock;
         if (tck_rise)
         begin
            tap_q <= tap_d;
            if (tap_q == TAP_CAP_IR)
               ir_sh_q <= IR_RESET;
            else if (tap_q == TAP_SHIFT_IR)
               ir_sh_q <= {test_data_in, ir_sh_q[IR_W-1:1]};
            if (tap_q == TAP_UPD_IR)
               ir_q <= ir_sh_q;
            else if (tap_q == TAP_RESET)
               ir_q <= IR_RESET;
            if (tap_q == TAP_CAP_DR)
               bypass_q <= 1'b0;
            else if (tap_q == TAP_SHIFT_DR)
               bypass_q <= test_data_in;
         end
      end
   end

   // Serial output updates on falling test clock only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo_q <= (tap_q == TAP_SHIFT_IR) ? ir_sh_q[0] : bypass_q;
         tdo_oe_q <= shifting;
      end
   end

   assign test_data_out = tdo_q;
   assign test_data_out_oe = tdo_oe_q;
endmodule

// ---- pkg/sram_pkg.sv ----
// Overview of operation
// - Rising edges act only while clock_qualify_n is low; else state holds. Lane drive still follows output_enable_n and sleep.
// - A high clock_qualify_n stretches the cycle; it never deselects.
// - Write data on the data lanes is captured on the rising clock edge.
// - Read data is driven one pipeline stage after its address edge.
// - Lanes drive only if output_enable_n is low and control allows it.
// - Lanes float in write data phase, after deselect, and while deselected.
// - Parity lanes follow the data lanes, gated per byte on writes.
// - burst_order_mode high or open gives interleaved order, low gives linear.
// - Test data out changes on falling test clock; data in samples rising.
// - Test mode select, sampled on rising test clock, steers the TAP machine.
// - A high sleep_request enters low-power sleep; stored contents are kept.
// - Controller holds sleep_request low in normal use; open reads as low.
// - Active-low byte_write_select_n, with write enable, gate byte lanes.
// - Selected only when first and third selects low and second high.
// - advance_or_load high advances the burst counter, low loads an address.
package sram_pkg;

   // Array shape
   localparam int MEM_AW = 4;
   localparam int MEM_DEPTH = 16;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int WORD_W = DATA_W + LANES;

   // Write log buffer shape
   localparam int LOG_W = 32;
   localparam int LOG_DEPTH = 8;

   // APB register byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] LOG_OFFSET = 8'h08;

   // Field positions
   localparam int CTRL_LOG_EN_BIT = 0;
   localparam int ST_ASLEEP_BIT = 0;
   localparam int ST_INTERLEAVE_BIT = 1;
   localparam int ST_ACTIVE_BIT = 2;
   localparam int ST_OVERFLOW_BIT = 3;
   localparam int ST_LOG_AVAIL_BIT = 4;

   // Values after reset
   localparam logic CTRL_LOG_EN_RESET = 1'b1;
   localparam logic [3:0] IR_RESET = 4'h1;

   // Test port instruction register width
   localparam int IR_W = 4;

   // Standard test access port states
   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
      TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
      TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } tap_state_t;

endpackage

// ---- pkg/log_fifo_if.sv ----
`timescale 1ns/1ns
interface log_fifo_if #(parameter int WIDTH = 32);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;

   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface

// ---- src/log_fifo.sv ----
`timescale 1ns/1ns
module log_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Both sides
   log_fifo_if.store port
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] count_q;
   wire push = port.push_valid && port.push_ready;
   wire pop = port.pop_valid && port.pop_ready;

   // Honest flags from the occupancy count
   assign port.push_ready = (count_q != (PW+1)'(DEPTH));
   assign port.pop_valid = (count_q != '0);
   assign port.pop_data = store_q[rd_q];

   // Pointers wrap at DEPTH, which need not be a power of two
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // Storage has no reset; only written slots are ever read
   always_ff @(posedge clk)
   begin
      if (push)
         store_q[wr_q] <= port.push_data;
   end
endmodule

// ---- bench/sram_device_chk.sv ----
`timescale 1ns/1ns
module sram_device_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Memory controls
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic write_enable_n,
   input wire logic advance_or_load,
   input wire logic clock_qualify_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   // Lanes and test port
   input wire logic [sram_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic parity_lane_oe,
   input wire logic test_clock,
   input wire logic test_data_out
);
   import sram_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Qualified load and full select
   wire sel = !chip_select_first_n && chip_select_second
      && !chip_select_third_n;
   wire ld = !clock_qualify_n && !advance_or_load;

   // OE guarded: a moving OE may legally float a held stage
   chk_stall_holds: assert property (
      clock_qualify_n && $stable(output_enable_n) |=>
      $stable(dq_out) && $stable(dq_oe))
      else $error("data stage moved during stall");
   chk_oe_float: assert property (
      output_enable_n && !clock_qualify_n |=> !dq_oe)
      else $error("lanes driven with output enable high");
   chk_desel_float: assert property (
      ld && !sel ##1 !clock_qualify_n |=> !dq_oe)
      else $error("lanes driven after deselect");
   chk_write_float: assert property (
      ld && sel && !write_enable_n ##1 !clock_qualify_n |=> !dq_oe)
      else $error("lanes driven in write data stage");
   // Sleep must have been low long enough to pass its synchroniser
   chk_read_drives: assert property (
      (!sleep_request)[*4] ##0 ld && sel && write_enable_n
      ##1 !clock_qualify_n && !output_enable_n |=> dq_oe)
      else $error("read data stage not driven");
   chk_parity_same: assert property (
      parity_lane_oe == dq_oe)
      else $error("parity drive differs from data drive");
   chk_tdo_falling: assert property (
      $changed(test_data_out) |-> !test_clock)
      else $error("test output moved while test clock high");
   chk_sleep_float: assert property (
      (sleep_request && !clock_qualify_n)[*7] |-> !dq_oe)
      else $error("lanes driven while asleep");
endmodule

bind sram_device sram_device_chk i_chk (.pclk, .presetn,
   .chip_select_first_n, .chip_select_second, .chip_select_third_n,
   .write_enable_n, .advance_or_load, .clock_qualify_n,
   .output_enable_n, .sleep_request, .dq_out, .dq_oe, .parity_lane_oe,
   .test_clock, .test_data_out);

// ---- bench/sram_ctrl_model.sv ----
`timescale 1ns/1ns
module sram_ctrl_model (
   // Clock
   input wire logic pclk,
   // Command pins
   output logic [sram_pkg::MEM_AW-1:0] addr,
   output logic chip_select_first_n,
   output logic chip_select_second,
   output logic chip_select_third_n,
   output logic write_enable_n,
   output logic advance_or_load,
   output logic [sram_pkg::LANES-1:0] byte_write_select_n,
   output logic clock_qualify_n,
   // Lanes towards the device
   output logic [sram_pkg::DATA_W-1:0] dq_in,
   output logic [sram_pkg::LANES-1:0] parity_lane_in
);
   import sram_pkg::*;
   // Idle and stalled at start, lanes low
   initial
   begin
      {addr, chip_select_first_n, chip_select_second} = 6'h2;
      {chip_select_third_n, write_enable_n, advance_or_load} = 3'h6;
      {byte_write_select_n, clock_qualify_n} = 5'h1f;
      {parity_lane_in, dq_in} = 36'h0;
   end

   // One qualified edge; c is {select, write_n, advance}
   task automatic cyc(input logic [3:0] a, input logic [2:0] c,
      input logic [3:0] bw, input logic drv, input logic [35:0] wd);
      addr <= a;
      chip_select_first_n <= !c[2];
      chip_select_second <= c[2];
      chip_select_third_n <= !c[2];
      write_enable_n <= c[1];
      advance_or_load <= c[0];
      byte_write_select_n <= bw;
      clock_qualify_n <= 1'h0;
      // Released lanes toggle so stale data never looks valid
      {parity_lane_in, dq_in} <= drv ? wd : ~{parity_lane_in, dq_in};
      @(posedge pclk);
   endtask

   // Pipeline stall of n edges
   task automatic stall(input int n);
      if (n > 0)
      begin
         clock_qualify_n <= 1'h1;
         repeat (n) @(posedge pclk);
      end
   endtask
endmodule

// ---- bench/sram_device_bench.sv ----
`timescale 1ns/1ns
module sram_device_bench;
   import sram_pkg::*;
   // Bench-driven inputs; mode only moves in reset
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, burst_order_mode = 1'h1, output_enable_n = 1'h0;
   logic sleep_request = 1'h0, test_clock = 1'h0;
   logic test_mode_select = 1'h0, test_data_in = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, dq_in, dq_out;
   logic [3:0] addr, byte_write_select_n, parity_lane_in, parity_lane_out;
   logic chip_select_first_n, chip_select_second, chip_select_third_n;
   logic write_enable_n, advance_or_load, clock_qualify_n, pready;
   logic pslverr, dq_oe, parity_lane_oe, test_data_out, test_data_out_oe;
   // Notes, shadow array and log model
   logic [35:0] exp_q[$];
   logic [35:0] mem[16];
   logic [31:0] log_q[$];
   logic last_q = 1'h0, log_en = 1'h1, ovf = 1'h0;
   int errors = 0, check_count = 0, seed = 32'h438c;

   always #10 pclk = ~pclk;

   sram_ctrl_model ctl (.pclk, .addr, .chip_select_first_n,
      .chip_select_second, .chip_select_third_n, .write_enable_n,
      .advance_or_load, .byte_write_select_n, .clock_qualify_n, .dq_in,
      .parity_lane_in);
   sram_device i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .addr, .chip_select_first_n,
      .chip_select_second, .chip_select_third_n, .write_enable_n,
      .advance_or_load, .byte_write_select_n, .clock_qualify_n,
      .output_enable_n, .burst_order_mode, .sleep_request, .dq_in, .dq_out,
      .dq_oe, .parity_lane_in, .parity_lane_out, .parity_lane_oe,
      .test_clock, .test_mode_select, .test_data_in, .test_data_out,
      .test_data_out_oe);

   task automatic check(input logic [35:0] seen, input logic [35:0] want);
      check_count++;
      if (seen !== want)
      begin
         errors++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic finish_test();
      errors += exp_q.size();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Held stages compare once: only after a qualified edge
   always @(posedge pclk)
   begin
      last_q <= !clock_qualify_n;
      if (presetn && last_q && dq_oe)
         check({parity_lane_out, dq_out}, exp_q.pop_front());
      if (psel && penable && pready && !pwrite)
         check({3'h0, pslverr, prdata}, exp_q.pop_front());
   end

   function automatic logic [35:0] rnd();
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      return r[35:0];
   endfunction

   function automatic logic [35:0] stat(input logic sl);
      return {31'h0, log_q.size() != 0, ovf, 1'h0, burst_order_mode, sl};
   endfunction

   task automatic rst(input logic m);
      presetn <= 1'h0;
      burst_order_mode <= m;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
   endtask

   // Read notes carry the pslverr bit above the data
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [35:0] want);
      if (!w)
         exp_q.push_back(want);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'h1;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // Lanes held over both edges after the load
   task automatic mwr(input logic [3:0] a, input logic [35:0] d,
      input logic [3:0] bw);
      ctl.cyc(a, 3'h4, bw, 1'h0, d);
      repeat (2) ctl.cyc(a, 3'h2, bw, 1'h1, d);
      for (int k = 0; k < 4; k++)
         if (!bw[k])
            {mem[a][32+k], mem[a][8*k +: 8]} = {d[32+k], d[8*k +: 8]};
      if (log_en && log_q.size() == 8)
         ovf = 1'h1;
      else if (log_en)
         log_q.push_back(d[31:0]);
   endtask

   // Load then advance n-1 times, stalling st edges after each
   task automatic mrd(input logic [3:0] a, input int n, input int st);
      logic [1:0] s;
      for (int k = 0; k < n; k++)
      begin
         s = burst_order_mode ? a[1:0] ^ k[1:0] : a[1:0] + k[1:0];
         if (!output_enable_n && !sleep_request)
            exp_q.push_back(mem[{a[3:2], s}]);
         ctl.cyc(a, k == 0 ? 3'h6 : 3'h7, 4'hf, 1'h0, 36'h0);
         ctl.stall(st);
      end
      ctl.cyc(a, 3'h2, 4'hf, 1'h0, 36'h0);
      ctl.stall(st);
      ctl.cyc(a, 3'h2, 4'hf, 1'h0, 36'h0);
   endtask

   // One slow test clock pulse, then look at the test output
   task automatic tck(input logic ms, input logic [1:0] want,
      input logic on);
      test_mode_select <= ms;
      test_data_in <= 1'h1;
      repeat (8) @(posedge pclk);
      test_clock <= 1'h1;
      repeat (8) @(posedge pclk);
      test_clock <= 1'h0;
      repeat (8) @(posedge pclk);
      if (on)
         check({34'h0, test_data_out_oe, test_data_out},
            {34'h0, want});
   endtask

   initial
   begin
      rst(1'h1);
      apb(1'h0, CTRL_OFFSET, 32'h0, 36'h1);
      apb(1'h0, STATUS_OFFSET, 32'h0, stat(1'h0));
      apb(1'h0, 8'h0c, 32'h0, 36'h1_0000_0000);
      $display("registers done");
      // Fill all words, then random byte gating on four
      for (int a = 0; a < 20; a++)
         mwr(a[3:0], rnd(), a < 16 ? 4'h0 : 4'($random(seed)));
      for (int a = 0; a < 16; a++)
      begin
         output_enable_n <= a == 3 || ($random(seed) & 7) == 0;
         @(posedge pclk);
         mrd(a[3:0], 1, $random(seed) & 3);
      end
      output_enable_n <= 1'h0;
      @(posedge pclk);
      mrd(4'h5, 4, 0);
      mrd(4'ha, 4, 2);
      $display("memory done");
      // Log is full and overflowed; drain past empty
      apb(1'h0, STATUS_OFFSET, 32'h0, stat(1'h0));
      for (int i = 0; i < 9; i++)
         apb(1'h0, LOG_OFFSET, 32'h0,
            log_q.size() != 0 ? {4'h0, log_q.pop_front()} : 36'h0);
      apb(1'h1, STATUS_OFFSET, 32'h8, 36'h0);
      ovf = 1'h0;
      apb(1'h1, CTRL_OFFSET, 32'h0, 36'h0);
      log_en = 1'h0;
      mwr(4'h9, rnd(), 4'h0);
      apb(1'h0, CTRL_OFFSET, 32'h0, 36'h0);
      apb(1'h0, STATUS_OFFSET, 32'h0, stat(1'h0));
      $display("log done");
      sleep_request <= 1'h1;
      repeat (8) @(posedge pclk);
      apb(1'h0, STATUS_OFFSET, 32'h0, stat(1'h1));
      mrd(4'h9, 1, 0);
      sleep_request <= 1'h0;
      repeat (8) @(posedge pclk);
      mrd(4'h9, 1, 0);
      $display("sleep done");
      // Reach shift-IR; captured value leaves first, then shifted ones
      for (int i = 0; i < 9; i++)
         tck(i == 1 || i == 2, i == 4 || i == 8 ? 2'h3 : 2'h2, i > 3);
      $display("test port done");
      rst(1'h0);
      mrd(4'h5, 4, 1);
      $display("linear burst done");
      finish_test();
   end

   // Run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      finish_test();
   end
endmodule
